// file: isd_top.sv
// The APB register port and the register addresses were decided locally.
`default_nettype none
module isd_top
   import isd_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RESET,
   input wire logic I_CE,
   // APB slave
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   output logic [DATA_W-1:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   // link side, same clock
   input wire logic I_SOF,
   input wire logic [2:0] I_UFRAME,
   input wire logic [FRAME_W-1:0] I_BUS_FRAME,
   output logic O_REQ_VALID,
   output logic [$bits(txn_req_type)-1:0] O_REQ,
   input wire logic I_REQ_READY,
   input wire logic I_RES_VALID,
   input wire logic [$bits(txn_result_type)-1:0] I_RES,
   output logic O_RES_READY,
   output logic O_ACTIVE
);
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_MASK = 8'h04;
   localparam logic [7:0] A_STAT = 8'h08;
   localparam logic [7:0] A_HI = 8'h0C;
   localparam int C_ACTIVE = 0;
   localparam int C_PHASE = 1;
   localparam int C_TOGGLE = 2;
   localparam int C_CERR = 3;
   localparam int C_TOKEN = 5;
   localparam int C_FRAME = 7;
   localparam int M_CS = 8;

   typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT} state_type;
   state_type state_r;

   logic active_r;
   logic phase_r;
   logic toggle_r;
   logic halt_r;
   logic [1:0] cerr_r;
   logic [1:0] token_r;
   logic [FRAME_W-1:0] frame_r;
   logic [7:0] ss_mask_r;
   logic [7:0] cs_mask_r;
   logic [BYTES_W-1:0] bytes_r;
   logic [2:0] cur_uf_r;
   txn_req_type req_r;
   logic [NUM_UF*STAT_W-1:0] stat_all;
   logic [NUM_UF-1:0] babble_v;
   logic [NUM_UF-1:0] xerr_v;
   logic is_in;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic load_ctrl;
   logic load_mask;
   logic ss_due;
   logic cs_due;
   logic res_v;
   logic [$bits(txn_result_type)-1:0] res_raw;
   txn_result_type res;
   logic take_res;
   logic fail;
   logic last_try;
   logic slot_clear;
   logic [NUM_UF-1:0] slot_upd;
   logic babble_sum;
   logic xerr_sum;

   assign is_in = (token_r == TOKEN_IN);
   assign addr_ok = (I_PADDR == A_CTRL) | (I_PADDR == A_MASK)
      | (I_PADDR == A_STAT) | (I_PADDR == A_HI);
   assign wr_en = I_CE & I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
   assign rd_en = I_CE & I_PSEL & ~I_PENABLE & ~I_PWRITE;
   assign load_ctrl = wr_en & addr_ok & (I_PADDR == A_CTRL);
   assign load_mask = wr_en & addr_ok & (I_PADDR == A_MASK);
   assign slot_clear = load_ctrl & I_PWDATA[C_ACTIVE];
   assign res = txn_result_type'(res_raw);
   assign take_res = res_v & (state_r == S_WAIT) & I_CE;
   assign fail = res.xerr | res.babble | res.underrun;
   assign last_try = (cerr_r == CERR_NONE);

   // OUT start split only in the matching frame
   assign ss_due = ss_mask_r[I_UFRAME] & ~phase_r
      & (is_in | (frame_r == I_BUS_FRAME));
   assign cs_due = cs_mask_r[I_UFRAME] & phase_r & is_in;

   // result path through a two-entry buffer
   isd_buf #(
      .WIDTH($bits(txn_result_type)),
      .DEPTH(BUF_DEPTH),
      .AW(BUF_AW)
   ) u_res_buf (
      .clk(I_MCLK),
      .rst(I_RESET),
      .ce(I_CE),
      .in_valid(I_RES_VALID),
      .in_ready(),
      .in_data(I_RES),
      .out_valid(res_v),
      .out_ready(state_r == S_WAIT),
      .out_data(res_raw)
   );

   genvar g;
   generate
      for (g = 0; g < NUM_UF; g++)
      begin : g_slot
         assign slot_upd[g] = take_res & (cur_uf_r == 3'(g));
         isd_slot u_slot (
            .clk(I_MCLK),
            .rst(I_RESET),
            .ce(I_CE),
            .clear(slot_clear),
            .upd(slot_upd[g]),
            .is_in(is_in),
            .xerr(res.xerr),
            .babble(res.babble),
            .underrun(res.underrun),
            .stat(stat_all[g*STAT_W +: STAT_W])
         );
         assign babble_v[g] = stat_all[g*STAT_W + ST_BABBLE];
         assign xerr_v[g] = stat_all[g*STAT_W + ST_XERR];
      end
   endgenerate

   assign babble_sum = |babble_v;
   assign xerr_sum = |xerr_v;

   // ready for results from the first enabled edge after reset on, request outstanding or not
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         O_RES_READY <= 1'b0;
      else if (I_CE)
         O_RES_READY <= 1'b1;
   end

   // scheduler
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         state_r <= S_IDLE;
         O_REQ_VALID <= 1'b0;
         req_r <= '0;
         cur_uf_r <= UF_ZERO;
      end
      else if (I_CE)
      begin
         unique case (state_r)
            S_IDLE:
            begin
               if (I_SOF & active_r & (ss_due | cs_due))
               begin
                  req_r.kind <= ss_due ? TK_SS : TK_CS;
                  req_r.uframe <= I_UFRAME;
                  req_r.token <= token_r;
                  req_r.toggle <= toggle_r;
                  cur_uf_r <= I_UFRAME;
                  O_REQ_VALID <= 1'b1;
                  state_r <= S_REQ;
               end
            end
            S_REQ:
            begin
               if (I_REQ_READY)
               begin
                  O_REQ_VALID <= 1'b0;
                  state_r <= S_WAIT;
               end
            end
            S_WAIT:
            begin
               if (take_res)
                  state_r <= S_IDLE;
            end
         endcase
      end
   end
   assign O_REQ = req_r;

   // descriptor word: software loads, hardware write-back
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         active_r <= 1'b0;
         phase_r <= 1'b0;
         toggle_r <= 1'b0;
         cerr_r <= CERR_NONE;
         token_r <= TOKEN_OUT;
         frame_r <= '0;
         bytes_r <= BYTES_ZERO;
      end
      else if (I_CE)
      begin
         if (load_ctrl)
         begin
            active_r <= I_PWDATA[C_ACTIVE];
            phase_r <= I_PWDATA[C_PHASE];
            toggle_r <= I_PWDATA[C_TOGGLE];
            cerr_r <= I_PWDATA[C_CERR +: 2];
            token_r <= I_PWDATA[C_TOKEN +: 2];
            frame_r <= I_PWDATA[C_FRAME +: FRAME_W];
            bytes_r <= BYTES_ZERO;
         end
         else if (take_res)
         begin
            bytes_r <= res.bytes;
            if (res.stall)
               active_r <= 1'b0;
            else if (fail)
            begin
               if (last_try)
               begin
                  active_r <= 1'b0;
                  cerr_r <= CERR_NONE;
               end
               else
                  cerr_r <= cerr_r - 2'h1;
            end
            else
            begin
               toggle_r <= res.toggle;
               if (req_r.kind == TK_SS && is_in)
                  phase_r <= 1'b1;
               if (((ss_mask_r & ~(8'h01 << cur_uf_r)) == 8'h00) &&
                   (!is_in || req_r.kind == TK_CS))
                  active_r <= 1'b0;
            end
         end
      end
   end

   // halt on stall
   // a stall taken in the cycle of a control write still sets it
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         halt_r <= 1'b0;
      else if (I_CE)
      begin
         if (take_res & res.stall)
            halt_r <= 1'b1;
         else if (load_ctrl)
            halt_r <= 1'b0;
      end
   end

   // masks: software sets, hardware clears after processing
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         ss_mask_r <= 8'h00;
         cs_mask_r <= 8'h00;
      end
      else if (I_CE)
      begin
         if (load_mask)
         begin
            // IN start split limited to microframes 0 to 3
            ss_mask_r <= I_PWDATA[7:0] & (token_r == TOKEN_IN ?
               IN_SS_ALLOWED : 8'hFF);
            cs_mask_r <= I_PWDATA[M_CS +: 8];
         end
         else if (take_res & ~(fail & ~last_try))
         begin
            if (req_r.kind == TK_SS)
               ss_mask_r[cur_uf_r] <= 1'b0;
            if (req_r.kind == TK_CS)
               cs_mask_r[cur_uf_r] <= 1'b0;
         end
      end
   end

   // APB read data, ready and error
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         O_PRDATA <= '0;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end
      else if (I_CE)
      begin
         O_PREADY <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= I_PSEL & ~I_PENABLE & ~addr_ok;
         if (rd_en)
         begin
            unique case (I_PADDR)
               A_CTRL:
                  O_PRDATA <= DATA_W'({frame_r, token_r, cerr_r,
                     toggle_r, phase_r, active_r});
               A_MASK:
                  O_PRDATA <= DATA_W'({cs_mask_r, ss_mask_r});
               A_STAT:
                  O_PRDATA <= DATA_W'({stat_all, 8'h00});
               A_HI:
                  O_PRDATA <= {active_r, halt_r, babble_sum, xerr_sum,
                     phase_r, 1'b0, toggle_r, cerr_r, 11'h000, bytes_r};
               default:
                  O_PRDATA <= '0;
            endcase
         end
      end
   end

   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
         O_ACTIVE <= 1'b0;
      else if (I_CE)
         O_ACTIVE <= active_r;
   end
endmodule
`default_nettype wire

// file: isd_pkg.sv
// Overview of operation
// - eight 3-bit per-microframe status slots; slots 2..0 at bits 16:14, 13:11, 10:8
// - status bit0 error either way, bit1 babble IN only, bit2 underrun OUT only
// - software sets start-split mask bits; device clears each after that microframe
// - OUT start split sent only when descriptor frame field equals bus frame
// - active bit 63 written like valid bit; device clears it when finished
// - halt bit 62 set when any microframe reports stall or halt
// - summary babble bit 61 follows status bit 1 of all slots
// - summary error bit 60 follows status bit 0 of all slots
// - error counter bits 56:55 loaded 00 means no retry
// - error counter 11 allows three retries, decremented on each retry
// - device writes byte count done, 12 bits at 43:32
// - complete-split mask, IN only; software sets, device clears after processing
// - token field 00 OUT, 01 IN
`default_nettype none
package isd_pkg;
   localparam int NUM_UF = 8;
   localparam int STAT_W = 3;
   localparam int BYTES_W = 12;
   localparam int FRAME_W = 5;
   localparam int DATA_W = 32;
   localparam int BUF_DEPTH = 2;
   localparam int BUF_AW = 1;
   // descriptor word 3 bit positions (upper word, 64-bit numbering)
   localparam int ACTIVE_BIT = 63;
   localparam int HALT_BIT = 62;
   localparam int BABBLE_BIT = 61;
   localparam int XERR_BIT = 60;
   localparam int PHASE_BIT = 59;
   localparam int TOGGLE_BIT = 57;
   localparam int CERR_LSB = 55;
   localparam int BYTES_LSB = 32;
   localparam int STAT_LSB = 8;
   localparam int ST_XERR = 0;
   localparam int ST_BABBLE = 1;
   localparam int ST_UNDERRUN = 2;
   localparam logic [1:0] TOKEN_OUT = 2'h0;
   localparam logic [1:0] TOKEN_IN = 2'h1;
   localparam logic [1:0] CERR_NONE = 2'h0;
   localparam logic [7:0] IN_SS_ALLOWED = 8'h0F;
   localparam logic [2:0] UF_ZERO = 3'h0;
   localparam logic [2:0] STAT_ZERO = 3'h0;
   localparam logic [11:0] BYTES_ZERO = 12'h000;
   // software-loaded descriptor fields
   typedef struct packed {
      logic active;
      logic phase;
      logic toggle;
      logic [1:0] cerr;
      logic [1:0] token;
      logic [FRAME_W-1:0] frame;
      logic [7:0] ss_mask;
      logic [7:0] cs_mask;
   } desc_load_type;
   // outcome of one bus transaction from the link logic
   typedef struct packed {
      logic ok;
      logic xerr;
      logic babble;
      logic underrun;
      logic stall;
      logic toggle;
      logic [BYTES_W-1:0] bytes;
   } txn_result_type;
   typedef enum logic [1:0] {TK_NONE, TK_SS, TK_CS} txn_kind_type;
   // request to the link: what to send this microframe
   typedef struct packed {
      txn_kind_type kind;
      logic [2:0] uframe;
      logic [1:0] token;
      logic toggle;
   } txn_req_type;
endpackage
`default_nettype wire

// file: isd_slot.sv
`default_nettype none
module isd_slot
   import isd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic clear,
   input wire logic upd,
   input wire logic is_in,
   input wire logic xerr,
   input wire logic babble,
   input wire logic underrun,
   output logic [STAT_W-1:0] stat
);
   always_ff @(posedge clk)
   begin
      if (rst)
         stat <= STAT_ZERO;
      else if (ce)
      begin
         // a result in the clear cycle wins over the clear
         if (upd)
         begin
            stat[ST_XERR] <= xerr;
            stat[ST_BABBLE] <= babble & is_in;
            stat[ST_UNDERRUN] <= underrun & ~is_in;
         end
         else if (clear)
            stat <= STAT_ZERO;
      end
   end
endmodule
`default_nettype wire

// file: isd_buf.sv
`default_nettype none
module isd_buf
   import isd_pkg::*;
#(
   parameter int WIDTH = DATA_W,
   parameter int DEPTH = BUF_DEPTH,
   parameter int AW = BUF_AW
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;
   assign in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rp_r];
   assign push = in_valid & in_ready & ce;
   assign pop = out_valid & out_ready & ce;
   always_ff @(posedge clk)
   begin
      if (push)
         mem_r[wp_r] <= in_data;
   end
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end
      else
      begin
         if (push)
            wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
         if (pop)
            rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
         if (push & ~pop)
            cnt_r <= cnt_r + 1'b1;
         else if (pop & ~push)
            cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: isd_chk.sv
`default_nettype none
module isd_chk
   import isd_pkg::*;
(
   input wire logic I_MCLK,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [DATA_W-1:0] I_PWDATA,
   input wire logic O_PREADY,
   input wire logic I_SOF,
   input wire logic [2:0] I_UFRAME,
   input wire logic [FRAME_W-1:0] I_BUS_FRAME,
   input wire logic O_REQ_VALID,
   input wire logic [$bits(txn_req_type)-1:0] O_REQ,
   input wire logic I_REQ_READY,
   input wire logic I_RES_VALID,
   input wire logic [$bits(txn_result_type)-1:0] I_RES,
   input wire logic O_ACTIVE
);
   txn_req_type rq;
   txn_result_type rs;
   logic [1:0] tok_r;
   logic [FRAME_W-1:0] frame_r;
   assign rq = O_REQ;
   assign rs = I_RES;
   // token and frame last written to the control word
   always_ff @(posedge I_MCLK)
   begin
      if (I_RESET)
      begin
         tok_r <= 2'h0;
         frame_r <= '0;
      end
      else if (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY
               && I_PADDR == 8'h00)
      begin
         tok_r <= I_PWDATA[6:5];
         frame_r <= I_PWDATA[11:7];
      end
   end
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (I_RESET);
   property p_answer;
      I_PSEL && !I_PENABLE |=> O_PREADY ##1 !O_PREADY;
   endproperty
   a_answer: assert property (p_answer) else $error("apb timing");
   property p_hold;
      O_REQ_VALID && !I_REQ_READY |=> O_REQ_VALID && $stable(O_REQ);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_slot;
      $rose(O_REQ_VALID) |-> $past(I_SOF) && rq.uframe == $past(I_UFRAME);
   endproperty
   a_slot: assert property (p_slot) else $error("request slot");
   property p_token;
      O_REQ_VALID |-> rq.token == tok_r;
   endproperty
   a_token: assert property (p_token) else $error("token");
   property p_frame;
      $rose(O_REQ_VALID) && rq.kind == TK_SS && rq.token == TOKEN_OUT
         |-> $past(I_BUS_FRAME) == frame_r;
   endproperty
   a_frame: assert property (p_frame) else $error("frame gate");
   property p_active;
      $rose(O_REQ_VALID) |-> O_ACTIVE;
   endproperty
   a_active: assert property (p_active) else $error("idle request");
   property p_stall;
      I_RES_VALID && rs.stall |-> ##[1:4] !O_ACTIVE;
   endproperty
   a_stall: assert property (p_stall) else $error("stall kept");
   property p_inlim;
      O_REQ_VALID && rq.token == TOKEN_IN && rq.kind == TK_SS
         |-> rq.uframe < 3'h4;
   endproperty
   a_inlim: assert property (p_inlim) else $error("in slot");
endmodule
bind isd_top isd_chk isd_chk_inst (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
   .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE),
   .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PREADY(O_PREADY),
   .I_SOF(I_SOF), .I_UFRAME(I_UFRAME), .I_BUS_FRAME(I_BUS_FRAME),
   .O_REQ_VALID(O_REQ_VALID), .O_REQ(O_REQ), .I_REQ_READY(I_REQ_READY),
   .I_RES_VALID(I_RES_VALID), .I_RES(I_RES), .O_ACTIVE(O_ACTIVE));
`default_nettype wire

// file: isd_link_model.sv
`default_nettype none
module isd_link_model
   import isd_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic [$bits(txn_req_type)-1:0] req,
   output logic req_ready,
   output logic res_valid,
   output logic [$bits(txn_result_type)-1:0] res,
   input wire logic [$bits(txn_result_type)-1:0] answer,
   input wire logic [3:0] lag,
   output txn_req_type last_req,
   output int unsigned done_cnt
);
   logic [3:0] cnt_r;
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         req_ready <= 1'h0;
         res_valid <= 1'h0;
         res <= '0;
         cnt_r <= 4'h0;
         done_cnt <= 0;
         last_req <= '0;
      end
      else
      begin
         res_valid <= 1'h0;
         // result lines carry nothing valid between pulses
         res <= ~res;
         if (req_ready)
         begin
            req_ready <= 1'h0;
            res_valid <= 1'h1;
            res <= answer;
            done_cnt <= done_cnt + 1;
         end
         else if (req_valid && cnt_r == lag)
         begin
            req_ready <= 1'h1;
            cnt_r <= 4'h0;
            last_req <= req;
         end
         else if (req_valid)
            cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule
`default_nettype wire

// file: interrupt_split_descriptor_status_bench.sv
`default_nettype none
module interrupt_split_descriptor_status_bench
   import isd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [1:0] tok;
      logic [2:0] uf;
      logic [4:0] fl;
      logic [2:0] st;
      logic [3:0] hi;
   } row_type;
   row_type rows [0:6];
   logic clk, rst, psel, pen, pwr, pready, perr, sof, rqv, rqr, rsv, act;
   logic ce, rrd;
   logic [7:0] paddr;
   logic [31:0] pwd, prd, q;
   logic [2:0] ufr;
   logic [4:0] bfr;
   logic [3:0] lag;
   logic [$bits(txn_req_type)-1:0] rq;
   logic [$bits(txn_result_type)-1:0] rs, ans;
   txn_req_type last;
   int unsigned dcnt;
   int bad_count, n_tests;
   logic e, got;
   isd_top isd_top_inst (.I_MCLK(clk), .I_RESET(rst), .I_CE(ce),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(pready), .O_PSLVERR(perr),
      .I_SOF(sof), .I_UFRAME(ufr), .I_BUS_FRAME(bfr), .O_REQ_VALID(rqv),
      .O_REQ(rq), .I_REQ_READY(rqr), .I_RES_VALID(rsv), .I_RES(rs),
      .O_RES_READY(rrd), .O_ACTIVE(act));
   isd_link_model isd_link_model_inst (.clk(clk), .rst(rst),
      .req_valid(rqv), .req(rq), .req_ready(rqr), .res_valid(rsv),
      .res(rs), .answer(ans), .lag(lag), .last_req(last), .done_cnt(dcnt));
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task end_of_test;
      $display("checks %0d errors %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'h1;
      pwr <= wr;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'h1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'h1 && n < 16);
      if (pready !== 1'h1)
      begin
         bad_count++;
         end_of_test;
      end
      q = prd;
      e = perr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task go(input logic [1:0] tk, input logic [1:0] ce, input logic tg,
           input logic [4:0] f, input logic [15:0] m);
      apb(1'h1, 8'h00, {20'h00000, f, tk, ce, tg, 1'h0, 1'h1});
      apb(1'h1, 8'h04, {16'h0000, m});
   endtask
   task shot(input logic [2:0] u, input logic [4:0] f,
             input logic [4:0] fl, input logic want);
      int unsigned c0;
      int n;
      c0 = dcnt;
      @(posedge clk);
      sof <= 1'h1;
      ufr <= u;
      bfr <= f;
      ans <= {fl, 1'h0, 12'h040};
      @(posedge clk);
      sof <= 1'h0;
      n = 0;
      while (dcnt == c0 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      got = (dcnt != c0);
      if (want && !got)
      begin
         bad_count++;
         end_of_test;
      end
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      rst = 1'h1;
      ce = 1'h1;
      psel = 1'h0;
      pen = 1'h0;
      pwr = 1'h0;
      paddr = 8'h00;
      pwd = 32'h0;
      sof = 1'h0;
      ufr = 3'h0;
      bfr = 5'h00;
      lag = 4'h0;
      ans = '0;
      bad_count = 0;
      n_tests = 0;
      rows = '{'{TOKEN_OUT, 3'h0, 5'h10, 3'h0, 4'h0},
               '{TOKEN_OUT, 3'h5, 5'h08, 3'h1, 4'h1},
               '{TOKEN_OUT, 3'h7, 5'h02, 3'h4, 4'h0},
               '{TOKEN_OUT, 3'h4, 5'h0C, 3'h1, 4'h1},
               '{TOKEN_OUT, 3'h6, 5'h01, 3'h0, 4'h4},
               '{TOKEN_IN, 3'h2, 5'h04, 3'h2, 4'h2},
               '{TOKEN_IN, 3'h1, 5'h0A, 3'h1, 4'h1}};
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      for (int a = 0; a < 4; a++)
      begin
         apb(1'h0, 8'(a * 4), 32'h0);
         chk(q, 32'h0);
      end
      for (int i = 0; i < 7; i++)
      begin
         lag <= 4'(i % 2 * 3);
         go(rows[i].tok, 2'h0, 1'h0, 5'(i), {8'h00, 8'(1 << rows[i].uf)});
         shot(rows[i].uf, 5'(i), rows[i].fl, 1'h1);
         apb(1'h0, 8'h08, 32'h0);
         chk({29'h0, q[8 + 3 * rows[i].uf +: 3]}, {29'h0, rows[i].st});
         apb(1'h0, 8'h0C, 32'h0);
         chk({28'h0, q[31:28]}, {28'h0, rows[i].hi});
         if (rows[i].fl[4])
            chk({20'h0, q[11:0]}, 32'h40);
         apb(1'h0, 8'h04, 32'h0);
         chk(q, 32'h0);
         shot(rows[i].uf, 5'(i), rows[i].fl, 1'h0);
         chk({31'h0, got}, 32'h0);
      end
      go(TOKEN_OUT, 2'h3, 1'h0, 5'h09, 16'h0001);
      shot(3'h0, 5'h0A, 5'h08, 1'h0);
      chk({31'h0, got}, 32'h0);
      for (int k = 0; k < 4; k++)
      begin
         shot(3'h0, 5'h09, 5'h08, 1'h1);
         apb(1'h0, 8'h0C, 32'h0);
         chk({30'h0, q[24:23]}, 32'(k < 3 ? 2 - k : 0));
         chk({31'h0, q[31]}, 32'(k < 3));
      end
      go(TOKEN_IN, 2'h0, 1'h1, 5'h03, 16'h04F1);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h401);
      shot(3'h0, 5'h03, 5'h10, 1'h1);
      chk({30'h0, last.kind}, {30'h0, TK_SS});
      chk({31'h0, last.toggle}, 32'h1);
      apb(1'h0, 8'h0C, 32'h0);
      chk({31'h0, q[27]}, 32'h1);
      shot(3'h2, 5'h03, 5'h10, 1'h1);
      chk({30'h0, last.kind}, {30'h0, TK_CS});
      apb(1'h0, 8'h0C, 32'h0);
      chk({q[31], 19'h0, q[11:0]}, 32'h40);
      apb(1'h0, 8'h04, 32'h0);
      chk(q, 32'h0);
      apb(1'h1, 8'h10, 32'hFFFFFFFF);
      chk({31'h0, e}, 32'h1);
      apb(1'h0, 8'h10, 32'h0);
      chk({e, q[30:0]}, 32'h80000000);
      // clock enable low freezes the scheduler
      go(TOKEN_OUT, 2'h0, 1'h0, 5'h01, 16'h0001);
      chk({31'h0, act}, 32'h1);
      ce <= 1'h0;
      shot(3'h0, 5'h01, 5'h10, 1'h0);
      chk({31'h0, got}, 32'h0);
      // reset in mid-run
      ce <= 1'h1;
      rst <= 1'h1;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      chk({31'h0, act}, 32'h0);
      chk({31'h0, rrd}, 32'h0);
      @(posedge clk);
      chk({31'h0, rrd}, 32'h1);
      apb(1'h0, 8'h00, 32'h0);
      chk(q, 32'h0);
      shot(3'h0, 5'h01, 5'h10, 1'h0);
      chk({31'h0, got}, 32'h0);
      end_of_test;
   end
endmodule
`default_nettype wire
